// ---- common/sccl_pkg.sv ----
`default_nettype none
package sccl_pkg;
    // oscillator index in the sampled tick and ready vectors
    localparam int OSC_FEXT = 0;
    localparam int OSC_FRC  = 1;
    localparam int OSC_MRC  = 2;
    localparam int OSC_SXT  = 3;
    localparam int OSC_SRC  = 4;
    localparam int NOSC     = 5;

    typedef enum logic [1:0] {
        SCCL_SYS_MRC  = 2'h0,
        SCCL_SYS_FRC  = 2'h1,
        SCCL_SYS_FEXT = 2'h2
    } sccl_sys_t;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_TRIM  = 5'h04;
    localparam logic [4:0] OFS_PRESC = 5'h08;
    localparam logic [4:0] OFS_GATE  = 5'h0c;
    localparam logic [4:0] OFS_STAT  = 5'h10;
    localparam logic [4:0] OFS_ISTAT = 5'h14;
    localparam logic [4:0] OFS_IMASK = 5'h18;
    localparam logic [4:0] OFS_MEAS  = 5'h1c;

    // field positions
    localparam int CTRL_SYS_LSB   = 0;
    localparam int CTRL_PLLREF    = 2;
    localparam int CTRL_RANGE_LSB = 4;
    localparam int CTRL_MON       = 8;
    localparam int CTRL_RTC_LSB   = 10;
    localparam int CTRL_OUT_LSB   = 12;
    localparam int TRIM_FRC_LSB   = 0;
    localparam int TRIM_MRC_LSB   = 8;
    localparam int PRE_AHB_LSB    = 0;
    localparam int PRE_APB1_LSB   = 4;
    localparam int PRE_APB2_LSB   = 8;
    localparam int GATE_PER_LSB   = 8;
    localparam int IRQ_FAIL       = 0;
    localparam int IRQ_SWITCH     = 1;

    // values after reset, and the bus prescale limit
    localparam logic [2:0] RST_RANGE    = 3'h5;
    localparam logic [4:0] RST_FRC_TRIM = 5'h10;
    localparam logic [7:0] RST_MRC_TRIM = 8'h80;
    localparam logic [3:0] MAX_AHB_PRE  = 4'h8;

    // slow crystal failure: no edge seen for this long
    localparam int SXT_FAIL_NS  = 100000;
    localparam int MCLK_PS      = 4000;
    localparam int SXT_FAIL_CYC = (SXT_FAIL_NS * 1000 + MCLK_PS - 1) / MCLK_PS;

    typedef struct packed {
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic [4:0]  prev;
        logic [4:0]  rdy1;
        logic [4:0]  rdy2;
        sccl_sys_t   sysSel;
        sccl_sys_t   activeSrc;
        logic        pllRef;
        logic [2:0]  range;
        logic        monEn;
        logic [1:0]  rtcSel;
        logic [2:0]  outSel;
        logic [4:0]  frcTrim;
        logic [7:0]  mrcTrim;
        logic [3:0]  ahbPre;
        logic [2:0]  apb1Pre;
        logic [2:0]  apb2Pre;
        logic [15:0] gate;
        logic [8:0]  ahbCnt;
        logic [7:0]  apb1Cnt;
        logic [7:0]  apb2Cnt;
        logic        sysTick;
        logic        ahbTick;
        logic        apb1Tick;
        logic        apb2Tick;
        logic        coreTick;
        logic        memTick;
        logic [7:0]  perTick;
        logic        rtcTick;
        logic        wdgTick;
        logic        pllRefTick;
        logic [4:0]  capTick;
        logic        frcOn;
        logic [3:0]  frcWakeTick;
        logic        clkOut;
        logic [15:0] monCnt;
        logic [15:0] measCnt;
        logic [15:0] measVal;
        logic [1:0]  irqStat;
        logic [1:0]  irqMask;
        logic        wakeEvent;
        logic [31:0] prdata;
    } sccl_state_t;
endpackage
`default_nettype wire

// ---- hw/sccl_system_clock_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
module sccl_system_clock_controller
    import sccl_pkg::*;
#(
    parameter int FAIL_CYCLES = SXT_FAIL_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  oscLevel,
    input  wire logic [4:0]  oscReady,
    input  wire logic        stopMode,
    input  wire logic [3:0]  wakeReq,
    output logic [2:0]       multispeed_rcRange,
    output logic [7:0]       multispeed_rcTrim,
    output logic [4:0]       fast_internal_rcTrim,
    output logic             fast_internal_rcOn,
    output logic             pllRefSel,
    output logic             pllRefTick,
    output logic             sysTick,
    output logic             ahbTick,
    output logic             apb1Tick,
    output logic             apb2Tick,
    output logic             coreTick,
    output logic             memTick,
    output logic [7:0]       perTick,
    output logic             rtcTick,
    output logic             watchdogTick,
    output logic [4:0]       timerCapTick,
    output logic [3:0]       wakePerTick,
    output logic             clock_output_pin,
    output logic             wakeEvent,
    output logic             irq
);
    sccl_state_t s_reg;
    sccl_state_t s_next;
    logic [4:0]  tick;
    logic        wrEn;
    logic        rdEn;
    logic        mapped;
    logic        srcTick;
    logic        ahbWrap;
    logic        sxtFail;
    logic [31:0] rdVal;

    function automatic int srcIdx(input sccl_sys_t sel);
        unique case (sel)
            SCCL_SYS_FRC:  return OSC_FRC;
            SCCL_SYS_FEXT: return OSC_FEXT;
            default:       return OSC_MRC;
        endcase
    endfunction

    function automatic logic [8:0] divMask(input logic [3:0] sh);
        return 9'((10'h001 << sh) - 10'h001);
    endfunction

    assign tick = s_reg.sync2 & ~s_reg.prev;
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & ~penable & ~pwrite;
    assign mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        unique case (paddr[4:0])
            OFS_CTRL:  rdVal = 32'({s_reg.outSel, s_reg.rtcSel, 1'b0, s_reg.monEn, 1'b0,
                                    s_reg.range, 1'b0, s_reg.pllRef, s_reg.sysSel});
            OFS_TRIM:  rdVal = 32'({s_reg.mrcTrim, 3'h0, s_reg.frcTrim});
            OFS_PRESC: rdVal = 32'({1'b0, s_reg.apb2Pre, 1'b0, s_reg.apb1Pre, s_reg.ahbPre});
            OFS_GATE:  rdVal = 32'(s_reg.gate);
            OFS_STAT:  rdVal = 32'({s_reg.frcOn, s_reg.rdy2, s_reg.activeSrc});
            OFS_ISTAT: rdVal = 32'(s_reg.irqStat);
            OFS_IMASK: rdVal = 32'(s_reg.irqMask);
            OFS_MEAS:  rdVal = 32'(s_reg.measVal);
            default:   rdVal = 32'h0;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        // second stage only reads the first; everything else looks at the second
        s_next.sync1 = oscLevel;
        s_next.sync2 = s_reg.sync1;
        s_next.prev  = s_reg.sync2;
        s_next.rdy1  = oscReady;
        s_next.rdy2  = s_reg.rdy1;

        // switch on the new source's own edge; the old source's last tick may still come just one cycle before it
        srcTick = tick[srcIdx(s_reg.activeSrc)];
        if (s_reg.sysSel != s_reg.activeSrc && s_reg.rdy2[srcIdx(s_reg.sysSel)]
            && tick[srcIdx(s_reg.sysSel)]) begin
            s_next.activeSrc = s_reg.sysSel;
            srcTick = 1'b1;
        end
        s_next.sysTick = srcTick;

        // every source is at most 32 MHz, so even divide-by-one stays in range
        ahbWrap = srcTick && (s_reg.ahbCnt & divMask(s_reg.ahbPre)) == divMask(s_reg.ahbPre);
        if (srcTick) begin
            s_next.ahbCnt = ahbWrap ? 9'h0 : 9'(s_reg.ahbCnt + 9'h1);
        end
        s_next.ahbTick = ahbWrap;
        s_next.apb1Tick = 1'b0;
        s_next.apb2Tick = 1'b0;
        if (ahbWrap) begin
            s_next.apb1Cnt = 8'(s_reg.apb1Cnt + 8'h1);
            s_next.apb2Cnt = 8'(s_reg.apb2Cnt + 8'h1);
            if ((s_reg.apb1Cnt & 8'(divMask({1'b0, s_reg.apb1Pre}))) == 8'(divMask({1'b0, s_reg.apb1Pre}))) begin
                s_next.apb1Tick = 1'b1;
                s_next.apb1Cnt = 8'h0;
            end
            if ((s_reg.apb2Cnt & 8'(divMask({1'b0, s_reg.apb2Pre}))) == 8'(divMask({1'b0, s_reg.apb2Pre}))) begin
                s_next.apb2Tick = 1'b1;
                s_next.apb2Cnt = 8'h0;
            end
        end
        s_next.coreTick = ahbWrap & s_reg.gate[0];
        s_next.memTick = ahbWrap & s_reg.gate[1];
        s_next.perTick = {8{ahbWrap}} & s_reg.gate[GATE_PER_LSB +: 8];

        unique case (s_reg.rtcSel)
            2'h1:    s_next.rtcTick = tick[OSC_SXT];
            2'h2:    s_next.rtcTick = tick[OSC_FEXT];
            default: s_next.rtcTick = tick[OSC_SRC];
        endcase
        s_next.wdgTick = tick[OSC_SRC];
        s_next.pllRefTick = s_reg.pllRef ? tick[OSC_FEXT] : tick[OSC_FRC];
        s_next.capTick = stopMode ? 5'h0 : tick;

        // fast RC runs while the system source, the PLL reference or a wake request needs it and drops once the last lets go
        s_next.frcOn = (s_reg.activeSrc == SCCL_SYS_FRC) || (s_reg.sysSel == SCCL_SYS_FRC)
                       || !s_reg.pllRef || (|wakeReq);
        s_next.frcWakeTick = {4{tick[OSC_FRC] & s_reg.frcOn}} & wakeReq;

        unique case (s_reg.outSel)
            3'h1:    s_next.clkOut = s_reg.sync2[OSC_FRC];
            3'h2:    s_next.clkOut = s_reg.sync2[OSC_MRC];
            3'h3:    s_next.clkOut = s_reg.sync2[OSC_FEXT];
            3'h4:    s_next.clkOut = s_reg.sync2[OSC_SXT];
            3'h5:    s_next.clkOut = s_reg.sync2[OSC_SRC];
            3'h6:    s_next.clkOut = s_reg.sync2[srcIdx(s_reg.activeSrc)];
            default: s_next.clkOut = 1'b0;
        endcase

        // slow RC period in fast RC edges, for watchdog calibration
        if (tick[OSC_SRC]) begin
            s_next.measVal = s_reg.measCnt;
            s_next.measCnt = 16'h0;
        end else if (tick[OSC_FRC] && s_reg.measCnt != 16'hffff) begin
            s_next.measCnt = 16'(s_reg.measCnt + 16'h1);
        end

        // crystal watchdog; the fast external clock is deliberately not watched
        sxtFail = 1'b0;
        if (!s_reg.monEn || tick[OSC_SXT]) begin
            s_next.monCnt = 16'h0;
        end else if (s_reg.monCnt != 16'(FAIL_CYCLES)) begin
            s_next.monCnt = 16'(s_reg.monCnt + 16'h1);
            sxtFail = (s_reg.monCnt == 16'(FAIL_CYCLES - 1));
        end
        s_next.wakeEvent = sxtFail;

        s_next.prdata = rdEn ? (mapped ? rdVal : 32'h0) : s_reg.prdata;
        if (wrEn && mapped) begin
            unique case (paddr[4:0])
                OFS_CTRL: begin
                    if (pwdata[CTRL_SYS_LSB +: 2] != 2'h3) begin
                        s_next.sysSel = sccl_sys_t'(pwdata[CTRL_SYS_LSB +: 2]);
                    end
                    s_next.pllRef = pwdata[CTRL_PLLREF];
                    if (pwdata[CTRL_RANGE_LSB +: 3] != 3'h7) begin
                        s_next.range = pwdata[CTRL_RANGE_LSB +: 3];
                    end
                    s_next.monEn = pwdata[CTRL_MON];
                    if (pwdata[CTRL_RTC_LSB +: 2] != 2'h3) begin
                        s_next.rtcSel = pwdata[CTRL_RTC_LSB +: 2];
                    end
                    s_next.outSel = pwdata[CTRL_OUT_LSB +: 3];
                end
                OFS_TRIM: begin
                    s_next.frcTrim = pwdata[TRIM_FRC_LSB +: 5];
                    s_next.mrcTrim = pwdata[TRIM_MRC_LSB +: 8];
                end
                OFS_PRESC: begin
                    // oversized divide codes clamp rather than wrap to a fast rate
                    s_next.ahbPre = (pwdata[PRE_AHB_LSB +: 4] > MAX_AHB_PRE) ? MAX_AHB_PRE
                                    : pwdata[PRE_AHB_LSB +: 4];
                    s_next.apb1Pre = pwdata[PRE_APB1_LSB +: 3];
                    s_next.apb2Pre = pwdata[PRE_APB2_LSB +: 3];
                end
                OFS_GATE:  s_next.gate = pwdata[15:0];
                OFS_ISTAT: s_next.irqStat = s_reg.irqStat & ~pwdata[1:0];
                OFS_IMASK: s_next.irqMask = pwdata[1:0];
                default: begin
                end
            endcase
        end
        // hardware set wins over a same-cycle clear
        if (sxtFail) begin
            s_next.irqStat[IRQ_FAIL] = 1'b1;
        end
        if (s_next.activeSrc != s_reg.activeSrc) begin
            s_next.irqStat[IRQ_SWITCH] = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.sysSel <= SCCL_SYS_MRC;
            s_reg.activeSrc <= SCCL_SYS_MRC;
            s_reg.range <= RST_RANGE;
            s_reg.frcTrim <= RST_FRC_TRIM;
            s_reg.mrcTrim <= RST_MRC_TRIM;
            s_reg.gate <= 16'hffff;
            s_reg.pllRef <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign multispeed_rcRange = s_reg.range;
    assign multispeed_rcTrim = s_reg.mrcTrim;
    assign fast_internal_rcTrim = s_reg.frcTrim;
    assign fast_internal_rcOn = s_reg.frcOn;
    assign pllRefSel = s_reg.pllRef;
    assign pllRefTick = s_reg.pllRefTick;
    assign sysTick = s_reg.sysTick;
    assign ahbTick = s_reg.ahbTick;
    assign apb1Tick = s_reg.apb1Tick;
    assign apb2Tick = s_reg.apb2Tick;
    assign coreTick = s_reg.coreTick;
    assign memTick = s_reg.memTick;
    assign perTick = s_reg.perTick;
    assign rtcTick = s_reg.rtcTick;
    assign watchdogTick = s_reg.wdgTick;
    assign timerCapTick = s_reg.capTick;
    assign wakePerTick = s_reg.frcWakeTick;
    assign clock_output_pin = s_reg.clkOut;
    assign wakeEvent = s_reg.wakeEvent;
    assign irq = |(s_reg.irqStat & s_reg.irqMask);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    srcSwitch_ready_a: assert property ($changed(s_reg.activeSrc) |->
        (($past(s_reg.rdy2) >> srcIdx(s_reg.activeSrc)) & 5'h01) != 5'h00)
        else $error("source switched before it was ready");
    srcSwitch_target_a: assert property ($changed(s_reg.activeSrc) |->
        s_reg.activeSrc == $past(s_reg.sysSel) && s_reg.sysTick && $past(s_reg.sysSel) != $past(s_reg.activeSrc))
        else $error("source switched to the wrong target");
    ahbDiv_a: assert property (s_reg.ahbTick |-> s_reg.sysTick)
        else $error("bus tick without system tick");
    ahbDirect_a: assert property (s_reg.sysTick && $past(s_reg.ahbPre) == 4'h0 |-> s_reg.ahbTick)
        else $error("undivided bus tick missing");
    apbSub_a: assert property (s_reg.apb1Tick || s_reg.apb2Tick |-> s_reg.ahbTick)
        else $error("peripheral bus tick without bus tick");
    coreGate_a: assert property (s_reg.coreTick |-> s_reg.ahbTick && $past(s_reg.gate[0]))
        else $error("core tick while gated");
    wakeFeed_a: assert property (|s_reg.frcWakeTick |-> $past(s_reg.frcOn) && $past(|wakeReq))
        else $error("wake tick without request");

    frcOn_a: assert property ($past(|wakeReq) |-> s_reg.frcOn)
        else $error("fast RC off while requested");

    failFlag_a: assert property ($rose(s_reg.irqStat[IRQ_FAIL]) |-> s_reg.wakeEvent && $past(s_reg.monEn))
        else $error("failure flag without monitor");

    monOff_a: assert property (!$past(s_reg.monEn) |-> !s_reg.wakeEvent)
        else $error("failure event with monitor off");

    stopCap_a: assert property (|s_reg.capTick |-> $past(!stopMode))
        else $error("timer capture tick in stop mode");

    // refused codes must never reach the state
    sysLegal_a: assert property (s_reg.sysSel != 2'h3 && s_reg.activeSrc != 2'h3)
        else $error("illegal system source code");

    rangeLegal_a: assert property (s_reg.range != 3'h7)
        else $error("illegal multispeed range");

    rtcLegal_a: assert property (s_reg.rtcSel != 2'h3)
        else $error("illegal rtc source code");

    ahbMax_a: assert property (s_reg.ahbPre <= MAX_AHB_PRE)
        else $error("bus prescale above limit");

    // derived ticks must trace back to the oscillator they claim; gated or disabled outputs must stay quiet
    sysOne_a: assert property (s_reg.sysTick |->
        $past(tick[srcIdx(s_reg.activeSrc)]) || $changed(s_reg.activeSrc))
        else $error("system tick from the wrong source");

    pllRef_a: assert property (s_reg.pllRefTick |-> $past(s_reg.pllRef ? tick[OSC_FEXT] : tick[OSC_FRC]))
        else $error("reference tick from the wrong source");

    rtcSrc_a: assert property (s_reg.rtcTick && $past(s_reg.rtcSel) == 2'h1 |-> $past(tick[OSC_SXT]))
        else $error("rtc tick without crystal edge");

    wdgSrc_a: assert property (s_reg.wdgTick == $past(tick[OSC_SRC]))
        else $error("watchdog tick not from slow RC");

    outOff_a: assert property ($past(s_reg.outSel) == 3'h0 |-> !s_reg.clkOut)
        else $error("clock output active while off");

    memGate_a: assert property (s_reg.memTick |-> s_reg.ahbTick && $past(s_reg.gate[1]))
        else $error("memory tick while gated");

    perGate_a: assert property ((s_reg.perTick & ~$past(s_reg.gate[GATE_PER_LSB +: 8])) == 8'h00)
        else $error("peripheral tick while gated");

    switchFext_c: cover property ($changed(s_reg.activeSrc) && s_reg.activeSrc == SCCL_SYS_FEXT);
    sxtFail_c: cover property ($rose(s_reg.irqStat[IRQ_FAIL]));
    wakeTick_c: cover property (|s_reg.frcWakeTick);
    apbDiv_c: cover property (s_reg.apb2Tick && s_reg.apb2Pre != 3'h0);
    pllFrc_c: cover property (s_reg.pllRefTick && !s_reg.pllRef);
endmodule
`default_nettype wire

// ---- sim/sccl_osc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// oscillators run from power-up; the block's reset does not stop them
module sccl_osc_model (
    input  wire logic       mclk,
    input  wire logic [4:0] runEn,
    input  wire logic [4:0] readyEn,
    output logic [4:0]      oscLevel,
    output logic [4:0]      oscReady
);
    // half periods in mclk cycles: fast ext, fast rc, multispeed, crystal, slow rc
    localparam int HALF [5] = '{4, 8, 10, 24, 32};
    int cnt [5] = '{0, 0, 0, 0, 0};
    initial oscLevel = 5'h00;
    assign oscReady = readyEn;
    // a stalled oscillator freezes its level, as a dead crystal would
    always @(posedge mclk) begin
        for (int i = 0; i < 5; i++) begin
            if (runEn[i] && cnt[i] == HALF[i] - 1) begin
                cnt[i] <= 0;
                oscLevel[i] <= ~oscLevel[i];
            end else if (runEn[i]) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/sccl_system_clock_controller_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module sccl_system_clock_controller_tb
    import sccl_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        stopMode = 1'b0;
    logic [3:0]  wakeReq = 4'h0;
    logic [4:0]  runEn = 5'h1f;
    logic [4:0]  readyEn = 5'h1f;
    logic [4:0]  oscLevel, oscReady, fast_internal_rcTrim, timerCapTick;
    logic [31:0] prdata, rd;
    logic [7:0]  multispeed_rcTrim, perTick;
    logic [3:0]  wakePerTick;
    logic [2:0]  multispeed_rcRange;
    logic        pready, pslverr, fast_internal_rcOn, pllRefSel, pllRefTick, sysTick, ahbTick, apb1Tick;
    logic        apb2Tick, coreTick, memTick, rtcTick, watchdogTick, clock_output_pin, wakeEvent, irq, err;
    logic        prevOut = 1'b0;
    int          n_errors = 0;
    int          comparisons = 0;
    int          c [16] = '{default: 0};
    int          d [16];

    sccl_osc_model u_sccl_osc_model (.mclk(mclk), .runEn(runEn), .readyEn(readyEn), .oscLevel(oscLevel),
        .oscReady(oscReady));

    sccl_system_clock_controller #(.FAIL_CYCLES(80)) u_sccl_system_clock_controller (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscLevel(oscLevel),
        .oscReady(oscReady), .stopMode(stopMode), .wakeReq(wakeReq), .multispeed_rcRange(multispeed_rcRange),
        .multispeed_rcTrim(multispeed_rcTrim), .fast_internal_rcTrim(fast_internal_rcTrim),
        .fast_internal_rcOn(fast_internal_rcOn), .pllRefSel(pllRefSel), .pllRefTick(pllRefTick),
        .sysTick(sysTick), .ahbTick(ahbTick), .apb1Tick(apb1Tick), .apb2Tick(apb2Tick), .coreTick(coreTick),
        .memTick(memTick), .perTick(perTick), .rtcTick(rtcTick), .watchdogTick(watchdogTick),
        .timerCapTick(timerCapTick), .wakePerTick(wakePerTick), .clock_output_pin(clock_output_pin),
        .wakeEvent(wakeEvent), .irq(irq));

    always #2 mclk = ~mclk;

    // free-running pulse counters; windows are taken as differences
    always @(posedge mclk) begin
        c[0] += sysTick;
        c[1] += ahbTick;
        c[2] += apb1Tick;
        c[3] += coreTick;
        c[4] += memTick;
        c[5] += perTick[0];
        c[6] += |perTick[7:1];
        c[7] += |timerCapTick;
        c[8] += wakePerTick[0];
        c[9] += |wakePerTick[3:1];
        c[10] += rtcTick;
        c[11] += watchdogTick;
        c[12] += (clock_output_pin !== prevOut);
        c[13] += wakeEvent;
        c[14] += apb2Tick;
        c[15] += pllRefTick;
        prevOut = clock_output_pin;
    end

    task automatic conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // oscillator phase against the window gives a tick or two of slack
    task automatic near(input string name, input int i, input int e);
        chk(name, 32'(d[i] >= e - 2 && d[i] <= e + 2), 32'h1);
    endtask

    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {27'h0, a};
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic measure(input int n);
        int s [16];
        repeat (8) @(posedge mclk);
        s = c;
        repeat (n) @(posedge mclk);
        foreach (d[i]) d[i] = c[i] - s[i];
    endtask

    task automatic waitSrc(input sccl_sys_t s);
        for (int k = 0; k < 40; k++) begin
            xfer(1'b0, OFS_STAT, 32'h0);
            if (rd[1:0] === s) break;
        end
        chk("activeSrc", rd[1:0], s);
    endtask

    task automatic t_reset;
        chk("range", multispeed_rcRange, RST_RANGE);
        chk("mrcTrim", multispeed_rcTrim, RST_MRC_TRIM);
        chk("frcTrim", fast_internal_rcTrim, RST_FRC_TRIM);
        chk("rcOn", fast_internal_rcOn, 32'h0);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h54);
        xfer(1'b0, OFS_GATE, 32'h0);
        chk("gate", rd, 32'hffff);
        waitSrc(SCCL_SYS_MRC);
        measure(200);
        near("mrcSys", 0, 10);
    endtask

    task automatic t_wake;
        wakeReq <= 4'h1;
        measure(200);
        chk("rcOnWake", fast_internal_rcOn, 32'h1);
        chk("wakeOwn", 32'(d[8] > 0), 32'h1);
        chk("wakeOther", d[9], 32'h0);
        wakeReq <= 4'h0;
        measure(8);
        chk("rcOff", fast_internal_rcOn, 32'h0);
    endtask

    task automatic t_cfg;
        for (int r = 0; r < 7; r++) begin
            xfer(1'b1, OFS_CTRL, 32'h4 | 32'(r << 4));
            chk("rangeSet", multispeed_rcRange, 32'(r));
        end
        xfer(1'b1, OFS_CTRL, 32'hc77);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("ctrlRefused", rd, 32'h64);
        chk("range7", multispeed_rcRange, 32'h6);
        xfer(1'b1, OFS_CTRL, 32'h50);
        chk("pllRef", pllRefSel, 32'h0);
        chk("rcOnRef", fast_internal_rcOn, 32'h1);
        measure(400);
        near("pllFrc", 15, 25);
        xfer(1'b1, OFS_CTRL, 32'h54);
        xfer(1'b1, OFS_TRIM, 32'h5a0b);
        chk("mrcTrimW", multispeed_rcTrim, 32'h5a);
        chk("frcTrimW", fast_internal_rcTrim, 32'h0b);
        xfer(1'b1, OFS_PRESC, 32'hf);
        xfer(1'b0, OFS_PRESC, 32'h0);
        chk("ahbClamp", rd[3:0], MAX_AHB_PRE);
        xfer(1'b1, OFS_PRESC, 32'h0);
        xfer(1'b0, 5'h03, 32'h0);
        chk("slvErr", err, 32'h1);
        chk("errData", rd, 32'h0);
    endtask

    task automatic t_crystal;
        xfer(1'b1, OFS_IMASK, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h554);
        measure(150);
        chk("noFail", d[13], 32'h0);
        chk("rtcXtal", 32'(d[10] > 0), 32'h1);
        runEn[3] <= 1'b0;
        measure(150);
        chk("failEv", 32'(d[13] > 0), 32'h1);
        chk("rtcDead", d[10], 32'h0);
        chk("irqFail", irq, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h54);
        xfer(1'b1, OFS_ISTAT, 32'h1);
        measure(150);
        chk("monOff", d[13], 32'h0);
        chk("rtcSlow", 32'(d[10] > 0), 32'h1);
        chk("wdg", 32'(d[11] > 0), 32'h1);
        chk("irqClr", irq, 32'h0);
        runEn[3] <= 1'b1;
    endtask

    task automatic t_out;
        measure(100);
        chk("outOff", d[12], 32'h0);
        xfer(1'b1, OFS_CTRL, 32'h1054);
        measure(400);
        near("outFrc", 12, 50);
        xfer(1'b0, OFS_MEAS, 32'h0);
        chk("meas", rd, 32'h4);
        xfer(1'b1, OFS_CTRL, 32'h6854);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("ctrlOut", rd, 32'h6854);
        measure(400);
        near("outSys", 12, 40);
        near("rtcFext", 10, 50);
        stopMode <= 1'b1;
        measure(100);
        chk("capStop", d[7], 32'h0);
        stopMode <= 1'b0;
        measure(100);
        chk("capRun", 32'(d[7] > 0), 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h54);
    endtask

    task automatic t_gate;
        xfer(1'b1, OFS_GATE, 32'h0);
        measure(200);
        chk("gatedAll", 32'(d[3] + d[4] + d[5] + d[6]), 32'h0);
        xfer(1'b1, OFS_GATE, 32'h0100);
        measure(200);
        chk("per0On", 32'(d[5] > 0), 32'h1);
        chk("othersOff", 32'(d[3] + d[4] + d[6]), 32'h0);
        xfer(1'b1, OFS_GATE, 32'h0003);
        measure(200);
        chk("coreMem", 32'(d[3] > 0 && d[4] > 0 && d[5] == 0), 32'h1);
        xfer(1'b1, OFS_GATE, 32'hffff);
    endtask

    task automatic t_switch;
        xfer(1'b1, OFS_CTRL, 32'h55);
        waitSrc(SCCL_SYS_FRC);
        measure(400);
        near("frcSys", 0, 25);
        xfer(1'b0, OFS_ISTAT, 32'h0);
        chk("swDone", rd[1:0], 32'h2);
        chk("irqMasked", irq, 32'h0);
        xfer(1'b1, OFS_IMASK, 32'h2);
        chk("irqOn", irq, 32'h1);
        xfer(1'b1, OFS_ISTAT, 32'h2);
        chk("irqW1c", irq, 32'h0);
        readyEn[0] <= 1'b0;
        xfer(1'b1, OFS_CTRL, 32'h56);
        measure(100);
        xfer(1'b0, OFS_STAT, 32'h0);
        chk("notReady", rd[1:0], SCCL_SYS_FRC);
        readyEn[0] <= 1'b1;
        waitSrc(SCCL_SYS_FEXT);
        measure(400);
        near("fextSys", 0, 50);
        near("pllFext", 15, 50);
        xfer(1'b1, OFS_PRESC, 32'h11);
        measure(400);
        near("ahbDiv", 1, 25);
        near("apb1Div", 2, 12);
        near("apb2Div", 14, 25);
    endtask

    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_wake();
        t_cfg();
        t_crystal();
        t_out();
        t_gate();
        t_switch();
        conclude();
    end
endmodule
`default_nettype wire
